// >>> rtl/rtw_top.sv
// rtc alarm, repeat counter, pin output and time/alarm register windows
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1: select field routes alarm, seconds or source
// RULE2: pin driven only while output enable set
// RULE3: alarm auto-disables at count zero without chime
// RULE4: chime wraps counter 00 to ff, else holds
// RULE5: mask codes 0-5 half second through hourly
// RULE6: codes 6-9 daily to yearly, leap aware
// RULE7: firmware avoids reserved mask codes
// RULE8: alarm pointer decrements on high access, stops 00
// RULE9: alarm pointer picks alarm byte per window
// RULE10: repeat counter decrements on each alarm
// RULE11: time pointer 3 gives year low, zero high
// RULE12: time pointers 0-2 map minute/second through month/day
// RULE13: year is two bcd digits
// RULE14: month tens bit4, ones bits 3-0
// RULE15: day tens bits 5-4, ones bits 3-0
// RULE16: weekday three bits, 0 to 6
// RULE17: hours tens bits 5-4, 24-hour count
// RULE18: minutes and seconds tens bits 6-4
// RULE19: date and hour writes need write enable
// RULE20: reserved time slot stores nothing, reads zero
// RULE21: time pointer decrements on high access, stops 00
// RULE22: time windows locked while write enable clear
// RULE23: bcd digits carry at ten, day rolls over
// RULE24: alarm fires when unmasked fields match
module rtw_top #(
   parameter int HALF_EDGES = rtw_pkg::HALF_SEC_EDGES
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [11:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic timebase_source_select,
   input wire logic crystal_oscillator,
   input wire logic internal_rc_oscillator,
   output logic clock_calendar_pin_out,
   output logic clock_calendar_pin_oe,
   output logic parallel_port_buffer_select
);
   import rtw_pkg::*;

   // ---- control state
   logic [1:0] pin_output_select_q;
   logic parallel_port_buffer_select_q;
   logic value_write_enable_q;
   logic clock_pin_output_enable_q;
   logic [1:0] time_window_pointer_q;
   logic [7:0] alarm_config_q;
   logic [7:0] alarm_repeat_count_q;
   logic [7:0] alarm_val_q [6];
   logic [7:0] rdata_q;
   logic alarm_toggle_q;
   logic pin_q;
   logic pin_oe_q;
   logic half_chk_q;
   logic sec_chk_q;

   // ---- time base and calendar
   logic src_level;
   logic half_level;
   logic half_tick;
   logic sec_tick;
   rtw_time_t now;
   rtw_wr_t cal_wr;

   rtw_timebase #(
      .HALF_EDGES(HALF_EDGES)
   ) u_timebase (
      .clk(clk),
      .rstn(rstn),
      .src_pins({internal_rc_oscillator, crystal_oscillator}),
      .src_sel(timebase_source_select),
      .src_level(src_level),
      .half_level(half_level),
      .half_tick(half_tick),
      .sec_tick(sec_tick)
   );

   rtw_calendar u_calendar (
      .clk(clk),
      .sec_tick(sec_tick),
      .wr(cal_wr),
      .now(now)
   );

   // ---- address decode
   wire hit_pad = sfr_addr == ADDR_PAD_CFG;
   wire hit_cfg = sfr_addr == ADDR_RTC_CFG;
   wire hit_alo = sfr_addr == ADDR_ALM_LO;
   wire hit_ahi = sfr_addr == ADDR_ALM_HI;
   wire hit_rpt = sfr_addr == ADDR_ALM_RPT;
   wire hit_acf = sfr_addr == ADDR_ALM_CFG;
   wire hit_tlo = sfr_addr == ADDR_TIM_LO;
   wire hit_thi = sfr_addr == ADDR_TIM_HI;
   wire any_acc = sfr_wr || sfr_rd;

   // ---- alarm config fields
   wire alarm_enable = alarm_config_q[ALM_EN_BIT];
   wire chime = alarm_config_q[ALM_CHIME_BIT];
   wire [3:0] alarm_interval_mask = alarm_config_q[ALM_MASK_LSB +: 4];
   wire [1:0] alarm_window_pointer = alarm_config_q[ALM_PTR_LSB +: 2];

   // ---- pointer stepping: both stop at 00
   wire time_hi_acc = any_acc && hit_thi;
   wire alarm_hi_acc = any_acc && hit_ahi;
   wire [1:0] tptr_step = (time_window_pointer_q == 2'h0) ? 2'h0
                        : time_window_pointer_q - 2'h1; // RULE21
   wire [1:0] aptr_step = (alarm_window_pointer == 2'h0) ? 2'h0
                        : alarm_window_pointer - 2'h1; // RULE8

   // ---- time window writes, locked without write enable
   wire time_wr = sfr_wr && (hit_tlo || hit_thi);
   assign cal_wr.en = time_wr && value_write_enable_q; // RULE19 RULE22
   assign cal_wr.high = hit_thi;
   assign cal_wr.ptr = time_window_pointer_q;
   assign cal_wr.data = sfr_wdata;

   // ---- alarm window: slot index is {pointer, high}; pointer 3 is absent
   wire [2:0] alarm_slot = {alarm_window_pointer, hit_ahi};
   wire alarm_slot_ok = alarm_window_pointer != 2'h3; // RULE9
   wire alarm_val_wr = sfr_wr && (hit_alo || hit_ahi) && alarm_slot_ok;
   logic [7:0] alarm_slot_bits;
   always_comb
   begin
      case (alarm_slot)
         3'd0, 3'd1: alarm_slot_bits = MINSEC_BITS;
         3'd2: alarm_slot_bits = HOUR_BITS;
         3'd3: alarm_slot_bits = WEEKDAY_VALUE_BITS;
         3'd4: alarm_slot_bits = DAY_BITS;
         default: alarm_slot_bits = MONTH_BITS;
      endcase
   end

   // ---- time window read mux
   logic [7:0] time_lo;
   logic [7:0] time_hi;
   always_comb
   begin
      case (time_window_pointer_q)
         2'h0:
         begin
            time_lo = now.seconds;
            time_hi = now.minutes; // RULE12
         end
         2'h1:
         begin
            time_lo = now.hours;
            time_hi = now.weekday; // RULE12
         end
         2'h2:
         begin
            time_lo = now.day;
            time_hi = now.month; // RULE12
         end
         default:
         begin
            time_lo = now.year;
            time_hi = 8'h00; // RULE11 RULE20
         end
      endcase
   end

   wire [7:0] alarm_rd = alarm_slot_ok ? alarm_val_q[alarm_slot] : 8'h00;

   // ---- register read mux; unmapped addresses read zero
   logic [7:0] rd_mux;
   always_comb
   begin
      rd_mux = 8'h00;
      if (hit_pad)
         rd_mux = {5'h0, pin_output_select_q, parallel_port_buffer_select_q};
      if (hit_cfg)
         rd_mux = {2'h0, value_write_enable_q, 1'b0, half_level,
                   clock_pin_output_enable_q, time_window_pointer_q};
      if (hit_acf)
         rd_mux = alarm_config_q;
      if (hit_rpt)
         rd_mux = alarm_repeat_count_q;
      if (hit_alo || hit_ahi)
         rd_mux = alarm_rd;
      if (hit_tlo)
         rd_mux = time_lo;
      if (hit_thi)
         rd_mux = time_hi;
   end

   // ---- alarm match, checked a cycle after the tick so counters settled
   wire m_sec1 = now.seconds[3:0] == alarm_val_q[0][3:0];
   wire m_sec = now.seconds == alarm_val_q[0];
   wire m_min1 = now.minutes[3:0] == alarm_val_q[1][3:0];
   wire m_min = now.minutes == alarm_val_q[1];
   wire m_hr = now.hours == alarm_val_q[2];
   wire m_wd = now.weekday == alarm_val_q[3];
   wire m_day = now.day == alarm_val_q[4];
   wire m_mon = now.month == alarm_val_q[5];
   wire m_hms = m_sec && m_min && m_hr;
   logic alarm_hit;
   always_comb
   begin
      case (alarm_interval_mask)
         MASK_HALF: alarm_hit = half_chk_q; // RULE5
         MASK_SEC: alarm_hit = sec_chk_q; // RULE5
         MASK_TEN_SEC: alarm_hit = sec_chk_q && m_sec1; // RULE5
         MASK_MIN: alarm_hit = sec_chk_q && m_sec; // RULE5
         MASK_TEN_MIN: alarm_hit = sec_chk_q && m_sec && m_min1; // RULE5
         MASK_HOUR: alarm_hit = sec_chk_q && m_sec && m_min; // RULE5
         MASK_DAY: alarm_hit = sec_chk_q && m_hms; // RULE6
         MASK_WEEK: alarm_hit = sec_chk_q && m_hms && m_wd; // RULE6
         MASK_MONTH: alarm_hit = sec_chk_q && m_hms && m_day; // RULE6
         // feb 29 only exists in leap years, so it fires every fourth
         MASK_YEAR: alarm_hit = sec_chk_q && m_hms && m_day && m_mon; // RULE6
         // reserved codes never fire
         default: alarm_hit = 1'b0; // RULE7
      endcase
   end
   wire alarm_event = alarm_enable && alarm_hit; // RULE24

   // ---- repeat counter and alarm config next values
   wire rpt_zero = alarm_repeat_count_q == 8'h00;
   wire [7:0] rpt_event = rpt_zero ? (chime ? RPT_WRAP : 8'h00) // RULE4
                        : alarm_repeat_count_q - 8'h01; // RULE10
   wire auto_off = alarm_event && rpt_zero && !chime; // RULE3
   wire [7:0] acfg_base = (sfr_wr && hit_acf) ? sfr_wdata : alarm_config_q;
   wire [1:0] aptr_next = alarm_hi_acc ? aptr_step : acfg_base[1:0];
   // the hardware clear lands after a same-cycle software write
   wire [7:0] acfg_next = {acfg_base[7] && !auto_off, acfg_base[6:2],
                           aptr_next};

   // ---- output pin source
   logic pin_sel;
   always_comb
   begin
      case (pin_output_select_q)
         SEL_ALARM: pin_sel = alarm_toggle_q; // RULE1
         SEL_SECONDS: pin_sel = half_level; // RULE1
         SEL_SOURCE: pin_sel = src_level; // RULE1
         default: pin_sel = 1'b0;
      endcase
   end

   // ---- control registers
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         pin_output_select_q <= PAD_CFG_RST[PAD_SEL_LSB +: 2];
         parallel_port_buffer_select_q <= PAD_CFG_RST[PAD_BUF_BIT];
      end
      else if (sfr_wr && hit_pad)
      begin
         pin_output_select_q <= sfr_wdata[PAD_SEL_LSB +: 2];
         parallel_port_buffer_select_q <= sfr_wdata[PAD_BUF_BIT];
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         value_write_enable_q <= 1'b0;
         clock_pin_output_enable_q <= 1'b0;
         time_window_pointer_q <= PTR_RST;
      end
      else if (sfr_wr && hit_cfg)
      begin
         value_write_enable_q <= sfr_wdata[CFG_WREN_BIT];
         clock_pin_output_enable_q <= sfr_wdata[CFG_OE_BIT];
         time_window_pointer_q <= sfr_wdata[CFG_PTR_LSB +: 2];
      end
      else if (time_hi_acc)
         time_window_pointer_q <= tptr_step; // RULE21
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         alarm_config_q <= ALM_CFG_RST;
         alarm_repeat_count_q <= ALM_RPT_RST;
      end
      else
      begin
         alarm_config_q <= acfg_next; // RULE3 RULE8
         if (alarm_event)
            alarm_repeat_count_q <= rpt_event; // RULE4 RULE10
         else if (sfr_wr && hit_rpt)
            alarm_repeat_count_q <= sfr_wdata;
      end
   end

   // alarm values power up unknown like the time values
   always_ff @(posedge clk)
   begin
      if (alarm_val_wr)
         alarm_val_q[alarm_slot] <= sfr_wdata & alarm_slot_bits; // RULE9
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         rdata_q <= 8'h00;
         alarm_toggle_q <= 1'b0;
         half_chk_q <= 1'b0;
         sec_chk_q <= 1'b0;
         pin_q <= 1'b0;
         pin_oe_q <= 1'b0;
      end
      else
      begin
         rdata_q <= sfr_rd ? rd_mux : rdata_q;
         alarm_toggle_q <= alarm_toggle_q ^ alarm_event;
         half_chk_q <= half_tick;
         sec_chk_q <= sec_tick;
         pin_q <= clock_pin_output_enable_q && pin_sel; // RULE2
         pin_oe_q <= clock_pin_output_enable_q; // RULE2
      end
   end

   assign sfr_rdata = rdata_q;
   assign clock_calendar_pin_out = pin_q;
   assign clock_calendar_pin_oe = pin_oe_q;
   assign parallel_port_buffer_select = parallel_port_buffer_select_q;
endmodule : rtw_top
`default_nettype wire

// >>> rtl/rtw_pkg.sv
// shared constants, types and bcd helpers for the rtc alarm and time window
package rtw_pkg;

   // register byte addresses on the special function register bus
   localparam logic [11:0] ADDR_PAD_CFG = 12'hf3c;
   localparam logic [11:0] ADDR_RTC_CFG = 12'hf3f;
   localparam logic [11:0] ADDR_ALM_LO = 12'hf8e;
   localparam logic [11:0] ADDR_ALM_HI = 12'hf8f;
   localparam logic [11:0] ADDR_ALM_RPT = 12'hf90;
   localparam logic [11:0] ADDR_ALM_CFG = 12'hf91;
   localparam logic [11:0] ADDR_TIM_LO = 12'hf98;
   localparam logic [11:0] ADDR_TIM_HI = 12'hf99;

   // field positions
   localparam int PAD_BUF_BIT = 0;
   localparam int PAD_SEL_LSB = 1;
   localparam int CFG_PTR_LSB = 0;
   localparam int CFG_OE_BIT = 2;
   localparam int CFG_HALF_BIT = 3;
   localparam int CFG_WREN_BIT = 5;
   localparam int ALM_PTR_LSB = 0;
   localparam int ALM_MASK_LSB = 2;
   localparam int ALM_CHIME_BIT = 6;
   localparam int ALM_EN_BIT = 7;

   // reset values
   localparam logic [2:0] PAD_CFG_RST = 3'h0;
   localparam logic [7:0] ALM_CFG_RST = 8'h00;
   localparam logic [7:0] ALM_RPT_RST = 8'h00;
   localparam logic [1:0] PTR_RST = 2'h0;

   // pin output select codes
   localparam logic [1:0] SEL_ALARM = 2'h0;
   localparam logic [1:0] SEL_SECONDS = 2'h1;
   localparam logic [1:0] SEL_SOURCE = 2'h2;

   // alarm interval mask codes
   localparam logic [3:0] MASK_HALF = 4'h0;
   localparam logic [3:0] MASK_SEC = 4'h1;
   localparam logic [3:0] MASK_TEN_SEC = 4'h2;
   localparam logic [3:0] MASK_MIN = 4'h3;
   localparam logic [3:0] MASK_TEN_MIN = 4'h4;
   localparam logic [3:0] MASK_HOUR = 4'h5;
   localparam logic [3:0] MASK_DAY = 4'h6;
   localparam logic [3:0] MASK_WEEK = 4'h7;
   localparam logic [3:0] MASK_MONTH = 4'h8;
   localparam logic [3:0] MASK_YEAR = 4'h9;

   // implemented bits of each value byte
   localparam logic [7:0] YEAR_BITS = 8'hff;
   localparam logic [7:0] MONTH_BITS = 8'h1f;
   localparam logic [7:0] DAY_BITS = 8'h3f;
   localparam logic [7:0] WEEKDAY_VALUE_BITS = 8'h07;
   localparam logic [7:0] HOUR_BITS = 8'h3f;
   localparam logic [7:0] MINSEC_BITS = 8'h7f;

   // bcd wrap points
   localparam logic [7:0] BCD_ZERO = 8'h00;
   localparam logic [7:0] BCD_ONE = 8'h01;
   localparam logic [7:0] MINSEC_LAST = 8'h59;
   localparam logic [7:0] HOUR_LAST = 8'h23;
   localparam logic [7:0] WEEKDAY_VALUE_LAST = 8'h06;
   localparam logic [7:0] MONTH_LAST = 8'h12;
   localparam logic [7:0] YEAR_LAST = 8'h99;
   localparam logic [7:0] RPT_WRAP = 8'hff;

   // time base: source edges in half a second
   localparam int SRC_CLK_HZ = 32768;
   localparam int HALF_SEC_EDGES = SRC_CLK_HZ / 2;

   typedef struct packed {
      logic [7:0] year;
      logic [7:0] month;
      logic [7:0] day;
      logic [7:0] weekday;
      logic [7:0] hours;
      logic [7:0] minutes;
      logic [7:0] seconds;
   } rtw_time_t;

   typedef struct packed {
      logic en;
      logic high;
      logic [1:0] ptr;
      logic [7:0] data;
   } rtw_wr_t;

   function automatic logic [7:0] rtw_bcd_inc(input logic [7:0] v,
      input logic [7:0] last, input logic [7:0] first);
      if (v == last)
         return first;
      else if (v[3:0] == 4'h9)
         return {v[7:4] + 4'h1, 4'h0};
      else
         return {v[7:4], v[3:0] + 4'h1};
   endfunction : rtw_bcd_inc

   // years 2000..2099: every year divisible by four is a leap year
   function automatic logic [7:0] rtw_last_day(input logic [7:0] month,
      input logic [7:0] year);
      logic leap;
      leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                     : (year[3:0] == 4'h0 || year[3:0] == 4'h4 ||
                        year[3:0] == 4'h8);
      case (month)
         8'h02: return leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
         default: return 8'h31;
      endcase
   endfunction : rtw_last_day

endpackage : rtw_pkg

// >>> rtl/rtw_timebase.sv
// source clock synchroniser and half-second divider
`timescale 1ns/1ps
`default_nettype none
module rtw_timebase #(
   parameter int HALF_EDGES = rtw_pkg::HALF_SEC_EDGES
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [1:0] src_pins,
   input wire logic src_sel,
   output logic src_level,
   output logic half_level,
   output logic half_tick,
   output logic sec_tick
);
   import rtw_pkg::*;

   localparam int CW = $clog2(HALF_EDGES);

   if (HALF_EDGES < 2)
      $error("rtw_timebase: HALF_EDGES must be at least 2");

   logic [1:0] lvl;
   logic [1:0] rise;
   logic [CW-1:0] cnt_q;
   logic half_q;
   logic half_tick_q;
   logic sec_tick_q;
   wire edge_sel = rise[src_sel];
   wire cnt_end = cnt_q == CW'(HALF_EDGES - 1);

   // a pin change counts only once the second and third stages agree
   for (genvar i = 0; i < 2; i++)
   begin : g_src
      logic [2:0] sh_q;
      logic lvl_q;
      wire agree = sh_q[1] == sh_q[2];
      always_ff @(posedge clk)
      begin
         if (!rstn)
         begin
            sh_q <= 3'h0;
            lvl_q <= 1'b0;
         end
         else
         begin
            sh_q <= {sh_q[1:0], src_pins[i]};
            lvl_q <= agree ? sh_q[1] : lvl_q;
         end
      end
      assign lvl[i] = lvl_q;
      assign rise[i] = agree && sh_q[1] && !lvl_q;
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         cnt_q <= '0;
         half_q <= 1'b0;
         half_tick_q <= 1'b0;
         sec_tick_q <= 1'b0;
      end
      else
      begin
         cnt_q <= edge_sel ? (cnt_end ? '0 : cnt_q + 1'b1) : cnt_q;
         half_q <= (edge_sel && cnt_end) ? ~half_q : half_q;
         half_tick_q <= edge_sel && cnt_end;
         sec_tick_q <= edge_sel && cnt_end && half_q;
      end
   end

   assign src_level = lvl[src_sel];
   assign half_level = half_q;
   assign half_tick = half_tick_q;
   assign sec_tick = sec_tick_q;
endmodule : rtw_timebase
`default_nettype wire

// >>> rtl/rtw_calendar.sv
// bcd time and date counters with windowed writes
`timescale 1ns/1ps
`default_nettype none
module rtw_calendar (
   input wire logic clk,
   input wire logic sec_tick,
   input wire rtw_pkg::rtw_wr_t wr,
   output rtw_pkg::rtw_time_t now
);
   import rtw_pkg::*;

   // value registers power up unknown and are not touched by reset
   rtw_time_t t_q;
   rtw_time_t inc;
   wire [7:0] last_day = rtw_last_day(t_q.month, t_q.year);
   wire sec_c = t_q.seconds == MINSEC_LAST;
   wire min_c = sec_c && t_q.minutes == MINSEC_LAST;
   wire hr_c = min_c && t_q.hours == HOUR_LAST;
   wire day_c = hr_c && t_q.day == last_day;
   wire mon_c = day_c && t_q.month == MONTH_LAST;

   // digits carry at ten; 23:59:59 rolls into the next day
   always_comb
   begin
      inc = t_q;
      inc.seconds = rtw_bcd_inc(t_q.seconds, MINSEC_LAST, BCD_ZERO); // RULE23
      if (sec_c)
         inc.minutes = rtw_bcd_inc(t_q.minutes, MINSEC_LAST, BCD_ZERO);
      if (min_c)
         inc.hours = rtw_bcd_inc(t_q.hours, HOUR_LAST, BCD_ZERO); // RULE23
      if (hr_c)
      begin
         inc.weekday = rtw_bcd_inc(t_q.weekday, WEEKDAY_VALUE_LAST, BCD_ZERO);
         inc.day = rtw_bcd_inc(t_q.day, last_day, BCD_ONE); // RULE23
      end
      if (day_c)
         inc.month = rtw_bcd_inc(t_q.month, MONTH_LAST, BCD_ONE);
      if (mon_c)
         inc.year = rtw_bcd_inc(t_q.year, YEAR_LAST, BCD_ZERO);
   end

   // a write in the same cycle as a tick wins for the whole set
   always_ff @(posedge clk)
   begin
      if (wr.en)
      begin
         case ({wr.ptr, wr.high})
            3'b000: t_q.seconds <= wr.data & MINSEC_BITS; // RULE18
            3'b001: t_q.minutes <= wr.data & MINSEC_BITS; // RULE18
            3'b010: t_q.hours <= wr.data & HOUR_BITS; // RULE17
            3'b011: t_q.weekday <= wr.data & WEEKDAY_VALUE_BITS; // RULE16
            3'b100: t_q.day <= wr.data & DAY_BITS; // RULE15
            3'b101: t_q.month <= wr.data & MONTH_BITS; // RULE14
            3'b110: t_q.year <= wr.data & YEAR_BITS; // RULE13
            default: t_q <= t_q; // RULE20
         endcase
      end
      else if (sec_tick)
         t_q <= inc;
   end

   assign now = t_q;
endmodule : rtw_calendar
`default_nettype wire

// >>> bench/rtw_chk_sva.sv
// port assertions for the rtc alarm and time window block
`timescale 1ns/1ps
`default_nettype none
module rtw_chk
   import rtw_pkg::*;
#(
   parameter int HALF_EDGES = 2
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [11:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic timebase_source_select,
   input wire logic crystal_oscillator,
   input wire logic internal_rc_oscillator,
   input wire logic clock_calendar_pin_out,
   input wire logic clock_calendar_pin_oe,
   input wire logic parallel_port_buffer_select
);
   wire logic mp;
   assign mp = sfr_addr inside {ADDR_PAD_CFG, ADDR_RTC_CFG, ADDR_ALM_LO,
      ADDR_ALM_HI, ADDR_ALM_RPT, ADDR_ALM_CFG, ADDR_TIM_LO, ADDR_TIM_HI};
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   sequence s_wr(a);
      sfr_wr && sfr_addr == a;
   endsequence
   sequence s_rd(a);
      sfr_rd && sfr_addr == a;
   endsequence
   // checked on the release edge, since the reset itself disables the rest
   property p_rst;
      $rose(rstn) |-> !clock_calendar_pin_oe && !clock_calendar_pin_out &&
         sfr_rdata == 8'h00 && !parallel_port_buffer_select;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not cleared");
   property p_off;
      !clock_calendar_pin_oe |-> !clock_calendar_pin_out;
   endproperty
   a_off: assert property (p_off) else $error("pin high while off");
   property p_oe;
      s_wr(ADDR_RTC_CFG) ##1 !sfr_wr [*3] |->
         clock_calendar_pin_oe == $past(sfr_wdata[CFG_OE_BIT], 3);
   endproperty
   a_oe: assert property (p_oe) else $error("enable not followed");
   property p_pad;
      s_wr(ADDR_PAD_CFG) ##2 s_rd(ADDR_PAD_CFG) |=>
         sfr_rdata == {5'h00, $past(sfr_wdata[2:0], 3)};
   endproperty
   a_pad: assert property (p_pad) else $error("pad cfg readback");
   property p_buf;
      s_wr(ADDR_PAD_CFG) ##1 !sfr_wr [*2] |->
         parallel_port_buffer_select == $past(sfr_wdata[PAD_BUF_BIT], 2);
   endproperty
   a_buf: assert property (p_buf) else $error("buffer select wrong");
   property p_unmap;
      sfr_rd && !mp |=> sfr_rdata == 8'h00;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not 0");
   property p_acfg;
      sfr_wr && sfr_addr == ADDR_ALM_CFG && !sfr_wdata[ALM_EN_BIT] ##2
         s_rd(ADDR_ALM_CFG) |=> sfr_rdata == $past(sfr_wdata, 3);
   endproperty
   a_acfg: assert property (p_acfg) else $error("alarm cfg readback");
   property p_hold;
      !sfr_rd |=> $stable(sfr_rdata);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
endmodule : rtw_chk
bind rtw_top rtw_chk #(.HALF_EDGES(HALF_EDGES)) u_chk (.clk(clk),
   .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
   .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
   .timebase_source_select(timebase_source_select),
   .crystal_oscillator(crystal_oscillator),
   .internal_rc_oscillator(internal_rc_oscillator),
   .clock_calendar_pin_out(clock_calendar_pin_out),
   .clock_calendar_pin_oe(clock_calendar_pin_oe),
   .parallel_port_buffer_select(parallel_port_buffer_select));
`default_nettype wire

// >>> bench/rtc_alarm_and_time_window_tb_top.sv
// self-checking bench for the rtc alarm and time window block
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_and_time_window_tb_top;
   import rtw_pkg::*;
   logic clk, rstn, wr, rd, tsel, run, po, pe, pb, pq;
   logic xo = 1'b0;
   logic rco = 1'b0;
   logic [11:0] ad;
   logic [7:0] wd, rdat, lf, v;
   logic [7:0] ex [8];
   logic [7:0] mk [8];
   logic [15:0] cyc = 16'h0000;
   int n_fail, n_compared, t0, n;
   int tg = 0;
   rtw_top #(.HALF_EDGES(2)) dut (.clk(clk), .rstn(rstn), .sfr_addr(ad),
      .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wd), .sfr_rdata(rdat),
      .timebase_source_select(tsel), .crystal_oscillator(xo),
      .internal_rc_oscillator(rco), .clock_calendar_pin_out(po),
      .clock_calendar_pin_oe(pe), .parallel_port_buffer_select(pb));
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // sources only move while run is set, so register walks see no ticks
   always @(posedge clk)
   begin
      cyc <= cyc + 16'h0001;
      if (run)
      begin
         xo <= cyc[3];
         rco <= cyc[2];
      end
      if (po !== pq)
         tg <= tg + 1;
      pq <= po;
   end
   function automatic logic [7:0] rnd();
      lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
      return lf;
   endfunction : rnd
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task bw(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      ad <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : bw
   task br(input logic [11:0] a);
      @(posedge clk);
      rd <= 1'b1;
      ad <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
   endtask : br
   // walks pointer 3 down to 0; w writes random bytes, up keeps them
   task win(input logic [11:0] ca, input logic [7:0] cv,
      input logic [11:0] wa, input bit w, input bit up);
      bw(ca, cv);
      for (int p = 3; p >= 0; p--)
         for (int h = 0; h < 2; h++)
         begin
            if (w)
            begin
               v = rnd();
               bw(wa + 12'(h), v);
               if (up)
                  ex[p*2+h] = v & mk[p*2+h];
            end
            else
            begin
               br(wa + 12'(h));
               chk(rdat, ex[p*2+h]);
            end
         end
   endtask : win
   task end_sim;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim
   initial
   begin
      #1000000;
      n_fail++;
      end_sim();
   end
   initial
   begin
      rstn = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      tsel = 1'b0;
      run = 1'b0;
      ad = 12'h000;
      wd = 8'h00;
      lf = 8'h26;
      n_fail = 0;
      n_compared = 0;
      mk = '{8'h7f, 8'h7f, 8'h3f, 8'h07, 8'h3f, 8'h1f, 8'hff, 8'h00};
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      br(ADDR_PAD_CFG);
      chk(rdat, 8'h00);
      br(ADDR_ALM_RPT);
      chk(rdat, 8'h00);
      br(12'hf00);
      chk(rdat, 8'h00);
      v = rnd();
      bw(ADDR_PAD_CFG, v);
      br(ADDR_PAD_CFG);
      chk(rdat, v & 8'h07);
      chk({7'h00, pb}, {7'h00, v[0]});
      win(ADDR_RTC_CFG, 8'h23, ADDR_TIM_LO, 1'b1, 1'b1);
      win(ADDR_RTC_CFG, 8'h23, ADDR_TIM_LO, 1'b0, 1'b0);
      win(ADDR_RTC_CFG, 8'h03, ADDR_TIM_LO, 1'b1, 1'b0);
      win(ADDR_RTC_CFG, 8'h03, ADDR_TIM_LO, 1'b0, 1'b0);
      br(ADDR_TIM_HI);
      chk(rdat, ex[1]);
      mk[6] = 8'h00;
      win(ADDR_ALM_CFG, 8'h03, ADDR_ALM_LO, 1'b1, 1'b1);
      win(ADDR_ALM_CFG, 8'h03, ADDR_ALM_LO, 1'b0, 1'b0);
      br(ADDR_ALM_HI);
      chk(rdat, ex[1]);
      bw(ADDR_PAD_CFG, 8'h00);
      bw(ADDR_RTC_CFG, 8'h04);
      bw(ADDR_ALM_RPT, 8'h02);
      bw(ADDR_ALM_CFG, 8'h84);
      t0 = tg;
      run <= 1'b1;
      repeat (800) @(posedge clk);
      run <= 1'b0;
      repeat (20) @(posedge clk);
      chk(8'(tg - t0), 8'h03);
      br(ADDR_ALM_CFG);
      chk(rdat, 8'h04);
      br(ADDR_ALM_RPT);
      chk(rdat, 8'h00);
      bw(ADDR_ALM_CFG, 8'hc0);
      t0 = tg;
      run <= 1'b1;
      repeat (320) @(posedge clk);
      run <= 1'b0;
      repeat (20) @(posedge clk);
      n = tg - t0;
      chk({7'h00, n >= 8 && n <= 11}, 8'h01);
      br(ADDR_ALM_RPT);
      chk(rdat, 8'(256 - n));
      bw(ADDR_ALM_CFG, 8'h00);
      br(ADDR_ALM_CFG);
      chk(rdat, 8'h00);
      run <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         tsel <= (i / 2 == 2);
         bw(ADDR_PAD_CFG, (i < 2) ? 8'h02 : 8'h04);
         bw(ADDR_RTC_CFG, {5'h00, i[0], 2'h0});
         t0 = tg;
         repeat (640) @(posedge clk);
         n = i[0] ? ((i < 2) ? 20 : (i < 4) ? 80 : 160) : 0;
         t0 = tg - t0 - n;
         chk({7'h00, t0 >= -2 && t0 <= 2}, 8'h01);
         chk({7'h00, pe}, {7'h00, i[0]});
      end
      // once a minute: seconds restart at 00, so only 05 matches in 20 s
      bw(ADDR_ALM_CFG, 8'h0c);
      bw(ADDR_ALM_LO, 8'h05);
      bw(ADDR_PAD_CFG, 8'h00);
      bw(ADDR_RTC_CFG, 8'h24);
      bw(ADDR_TIM_LO, 8'h00);
      bw(ADDR_ALM_CFG, 8'h8c);
      t0 = tg;
      repeat (640) @(posedge clk);
      chk(8'(tg - t0), 8'h01);
      end_sim();
   end
endmodule : rtc_alarm_and_time_window_tb_top
`default_nettype wire
